// ===== flash_sector_program_protect.sv
/*
 flash program memory controller: sectored erase, byte programming, mode-based
 sector permission, read-out protection with erase on removal, link pin ownership.
 assumes a classic wishbone master on clk_i and an external tool on the link pins.
*/
// Behaviour
// - flash is erased as a whole block or by sector and programmed a byte at a time.
// - erasing or programming one sector leaves every other sector unchanged.
// - with the tool attached or in in-circuit programming mode every sector and the option byte are writable.
// - in in-application programming mode sector 0 is write and erase protected.
// - a 4K array has sector 0, an 8K array sectors 0 and 1, larger arrays sectors 0, 1 and 2.
// - sectors 0 and 1 are 4K each at the top, sector 0 at f000-ffff holding the vectors.
// - read-out protection blocks external reads of the array and all program, sector erase and bulk erase commands; option byte writes still go through.
// - removing read-out protection first erases the whole array, then allows programming.
// - read-out protection is one bit of the option byte.
// - while the tool is attached the serial clock and data pins are withheld from the application.
// - the link uses reset, ground, serial clock, two-way data, programming voltage and optional clock.
// - the 8-bit control and status register resets to zero and steers program and erase.
// - program and erase start only after a guard key sequence, so stray writes do nothing.
module flash_sector_program_protect
    import flash_ctrl_pkg::*;
#(
    parameter int FLASH_BYTES = 16384
) (
    // system
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // link side; serial data in and select sampled on the tool's serial clock
    input  wire logic        incircuit_serial_clock,
    input  wire logic        incircuit_serial_data_i,
    output logic             incircuit_serial_data_o,
    output logic             incircuit_serial_data_oe_o,
    input  wire logic        programming_voltage_select_i,
    input  wire logic        tool_attached_i,
    // application view of shared pins
    input  wire logic        app_data_o_i,
    input  wire logic        app_data_oe_i,
    output logic             app_pins_avail_o,
    output logic             incircuit_comm_mode_o,
    output logic             readout_protect_o
);
    // ------------------------------------------------------------
    // parameter checks and geometry
    // ------------------------------------------------------------
    localparam int AW = $clog2(FLASH_BYTES);
    localparam logic [1:0] TOP_SECT = (FLASH_BYTES <= SIZE_4K) ? 2'd0 :
                                      (FLASH_BYTES <= SIZE_8K) ? 2'd1 : 2'd2;
    localparam logic [15:0] LOW_BASE = 16'(17'h10000 - 17'(FLASH_BYTES));
    initial begin
        // the array index is the low address bits, so only powers of two map cleanly
        if (FLASH_BYTES < SIZE_4K || FLASH_BYTES > 65536 || (FLASH_BYTES % SECT_FIXED_BYTES) != 0 ||
            (FLASH_BYTES & (FLASH_BYTES - 1)) != 0)
            $error("FLASH_BYTES must be a power of two between 4K and 64K");
    end

    // sector of a cpu address; 3 means outside the array
    function automatic logic [1:0] sector_of(input logic [15:0] a);
        if (a >= SECT0_BASE)                          sector_of = 2'd0;
        else if (a >= SECT1_BASE && TOP_SECT >= 2'd1) sector_of = 2'd1;
        else if (a >= LOW_BASE && TOP_SECT == 2'd2)   sector_of = 2'd2;
        else                                          sector_of = 2'd3;
    endfunction

    logic [7:0] mem [FLASH_BYTES];

    // ------------------------------------------------------------
    // link domain: tool pins on the serial clock
    // ------------------------------------------------------------
    logic       lk_sess_q;
    logic [7:0] lk_shift_q;
    logic       lk_data_q;
    always_ff @(posedge incircuit_serial_clock) begin
        lk_sess_q <= programming_voltage_select_i;
        lk_shift_q <= {lk_shift_q[6:0], incircuit_serial_data_i};
        lk_data_q  <= lk_shift_q[7];
    end

    // ------------------------------------------------------------
    // crossings into clk_i
    // ------------------------------------------------------------
    // the select pin also passes its own pair of flip-flops: the link copy stays
    // unknown until the tool first clocks it, and the pin copy masks that
    logic [1:0] sess_s_q;
    logic [1:0] tool_s_q;
    logic [1:0] psel_s_q;
    logic       icc_q;
    logic       tool_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sess_s_q <= 2'b00;
            tool_s_q <= 2'b00;
            psel_s_q <= 2'b00;
        end else begin
            sess_s_q <= {sess_s_q[0], lk_sess_q};
            tool_s_q <= {tool_s_q[0], tool_attached_i};
            psel_s_q <= {psel_s_q[0], programming_voltage_select_i};
        end
    end
    assign icc_q  = psel_s_q[1] && sess_s_q[1];
    assign tool_q = tool_s_q[1];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]  ctl_q;
    logic [7:0]  opt_q;
    logic [7:0]  data_q;
    logic [7:0]  rdata_q;
    logic [15:0] addr_q;
    logic [1:0]  guard_q;
    logic        refused_q;
    logic        ack_q;
    logic [31:0] dat_q;
    op_state_t   st_q;
    logic [AW:0] cnt_q;
    logic        bulk_q;
    logic        then_unprot_q;
    logic [1:0]  esect_q;

    wire req     = cyc_i && stb_i && !ack_q;
    // writes land at the edge that returns ack, never on the taking edge
    wire wr_req  = cyc_i && stb_i && we_i && sel_i[0] && ack_q;
    wire full_ok = tool_q || icc_q;
    wire protect = opt_q[OPT_PROTECT_BIT];
    wire armed   = guard_q == 2'd2;
    wire [1:0] tsect = (wr_req && adr_i == FPCS_OFF) ? dat_i[CTL_SECT_LSB +: 2] : 2'd0;
    wire [1:0] asect = sector_of(addr_q);

    // permission: sector allowed in current mode
    function automatic logic sect_ok(input logic [1:0] s, input logic full, input logic [1:0] top);
        sect_ok = (s <= top) && (full || s != 2'd0);
    endfunction

    wire start_cmd = wr_req && adr_i == FPCS_OFF && armed && st_q == ST_IDLE;
    wire go_prog = start_cmd && dat_i[CTL_PROG_BIT] && !protect && asect != 2'd3 &&
                   sect_ok(asect, full_ok, TOP_SECT);
    wire go_sect = start_cmd && dat_i[CTL_SECT_ERASE_BIT] && !protect &&
                   sect_ok(tsect, full_ok, TOP_SECT);
    wire go_bulk = start_cmd && dat_i[CTL_BULK_ERASE_BIT] && full_ok && !protect;
    wire go_opt  = start_cmd && dat_i[CTL_OPT_WRITE_BIT] && full_ok;
    wire opt_unprot = go_opt && protect && !data_q[OPT_PROTECT_BIT];
    wire any_go = go_prog || go_sect || go_bulk || go_opt;

    // guard: two key writes arm one command
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            guard_q <= 2'd0;
        end else if (wr_req && adr_i == GUARD_OFF && dat_i[7:0] == GUARD_KEY1) begin
            guard_q <= 2'd1;
        end else if (wr_req && adr_i == GUARD_OFF && dat_i[7:0] == GUARD_KEY2 && guard_q == 2'd1) begin
            guard_q <= 2'd2;
        end else if (wr_req) begin
            guard_q <= 2'd0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_q  <= FPCS_RESET;
            addr_q <= 16'h0000;
            data_q <= 8'h00;
        end else if (wr_req) begin
            if (adr_i == FPCS_OFF)  ctl_q  <= dat_i[7:0];
            if (adr_i == ADDR_OFF)  addr_q <= dat_i[15:0];
            if (adr_i == DATA_OFF)  data_q <= dat_i[7:0];
        end
    end

    // refused flag: set when an armed command is refused while idle, cleared by the next accepted one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            refused_q <= 1'b0;
        end else if (start_cmd && !any_go && |dat_i[3:0]) begin
            refused_q <= 1'b1;
        end else if (any_go) begin
            refused_q <= 1'b0;
        end
    end

    // option byte; removal of protection waits for the full erase
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opt_q <= OPTION_RESET;
        end else if (go_opt && !opt_unprot) begin
            opt_q <= data_q;
        end else if (st_q == ST_ERASE && then_unprot_q && cnt_q == '0) begin
            opt_q <= data_q;
        end
    end

    // ------------------------------------------------------------
    // program and erase sequencer
    // ------------------------------------------------------------
    wire [15:0] cnt_addr = 16'(LOW_BASE + 16'(cnt_q[AW-1:0]));
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= ST_IDLE;
            cnt_q <= '0;
            bulk_q <= 1'b0;
            then_unprot_q <= 1'b0;
            esect_q <= 2'd0;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    if (go_prog) begin
                        st_q <= ST_PROG;
                    end else if (go_sect || go_bulk || opt_unprot) begin
                        st_q <= ST_ERASE;
                        cnt_q <= (AW+1)'(FLASH_BYTES - 1);
                        bulk_q <= go_bulk || opt_unprot;
                        then_unprot_q <= opt_unprot;
                        esect_q <= tsect;
                    end
                end
                ST_PROG: st_q <= ST_IDLE;
                ST_ERASE: begin
                    if (cnt_q == '0) begin
                        st_q <= ST_IDLE;
                        then_unprot_q <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // array: byte write and one byte erased per cycle
    always_ff @(posedge clk_i) begin
        if (st_q == ST_PROG)
            mem[addr_q[AW-1:0]] <= mem[addr_q[AW-1:0]] & data_q;
        else if (st_q == ST_ERASE && (bulk_q || sector_of(cnt_addr) == esect_q))
            mem[cnt_q[AW-1:0]] <= 8'hff;
    end

    // ------------------------------------------------------------
    // read path and bus answer
    // ------------------------------------------------------------
    wire ext_read = full_ok; // array reads from outside the application
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= (protect && ext_read) ? 8'h00 : mem[addr_q[AW-1:0]];
        end
    end

    wire [7:0] status = 8'(({7'd0, st_q != ST_IDLE} << ST_BUSY_BIT) |
        ({7'd0, refused_q} << ST_REFUSED_BIT) | ({7'd0, protect} << ST_PROTECT_BIT) |
        ({7'd0, tool_q} << ST_TOOL_BIT) | ({7'd0, icc_q} << ST_ICC_BIT) |
        ({7'd0, !full_ok} << ST_IAP_BIT));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            unique case (adr_i)
                FPCS_OFF:   dat_q <= {24'h000000, ctl_q};
                ADDR_OFF:   dat_q <= {16'h0000, addr_q};
                DATA_OFF:   dat_q <= {24'h000000, data_q};
                OPTION_OFF: dat_q <= {24'h000000, opt_q};
                STATUS_OFF: dat_q <= {24'h000000, status};
                RDATA_OFF:  dat_q <= {24'h000000, rdata_q};
                default:    dat_q <= 32'h0000_0000;
            endcase
        end
    end
    assign ack_o = ack_q;
    assign dat_o = dat_q;

    // ------------------------------------------------------------
    // shared pin ownership
    // ------------------------------------------------------------
    logic avail_q;
    logic icc_out_q;
    logic prot_out_q;
    logic pdo_q;
    logic poe_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            avail_q <= 1'b1;
            icc_out_q <= 1'b0;
            prot_out_q <= 1'b0;
            pdo_q <= 1'b0;
            poe_q <= 1'b0;
        end else begin
            avail_q <= !tool_q;
            icc_out_q <= icc_q;
            prot_out_q <= protect;
            pdo_q <= tool_q ? 1'b0 : app_data_o_i;
            poe_q <= tool_q ? 1'b0 : app_data_oe_i;
        end
    end
    assign app_pins_avail_o = avail_q;
    assign incircuit_comm_mode_o = icc_out_q;
    assign readout_protect_o = prot_out_q;
    assign incircuit_serial_data_o = pdo_q;
    assign incircuit_serial_data_oe_o = poe_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sector0_guard_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q == ST_IDLE && !full_ok) |=> !(st_q == ST_PROG && sector_of(addr_q) == 2'd0))
        else $error("sector 0 programmed in application mode");
    protect_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (protect && st_q == ST_IDLE) |=> st_q != ST_PROG)
        else $error("program started while protected");
    unprot_erase_a: assert property (@(posedge clk_i) disable iff (rst_i)
        opt_unprot |=> (st_q == ST_ERASE && bulk_q && protect))
        else $error("protection removal without full erase");
    guard_need_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q == ST_IDLE && !armed) |=> st_q == ST_IDLE)
        else $error("operation started without guard");
    ctl_reset_a: assert property (@(posedge clk_i) $fell(rst_i) |-> ctl_q == 8'h00)
        else $error("control register not zero after reset");
    pins_withheld_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(tool_q) |=> !app_pins_avail_o && !incircuit_serial_data_oe_o)
        else $error("link pins left to application");
    refuse_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (start_cmd && !any_go && |dat_i[3:0]) |=> refused_q && st_q == ST_IDLE)
        else $error("refused command not flagged");
    ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held two cycles");
    bus_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (cyc_i && stb_i && !ack_o) |=> ack_o)
        else $error("request not answered in one cycle");
    ctl_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_req && adr_i == FPCS_OFF) |=> ctl_q == $past(dat_i[7:0]))
        else $error("control write lost");
    prog_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        go_prog |=> st_q == ST_PROG)
        else $error("accepted program did not start");
    prog_one_shot_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == ST_PROG |=> st_q == ST_IDLE)
        else $error("program step longer than one cycle");
    erase_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q == ST_ERASE && cnt_q != '0) |=> (st_q == ST_ERASE && cnt_q == $past(cnt_q) - 1'b1))
        else $error("erase counter skipped");
    erase_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q == ST_ERASE && cnt_q == '0) |=> st_q == ST_IDLE)
        else $error("erase did not end");
    sect_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (go_sect && !go_prog && !go_bulk && !opt_unprot) |=> (st_q == ST_ERASE && !bulk_q))
        else $error("sector erase widened to the whole array");
    opt_locked_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q == ST_IDLE && !full_ok) |=> $stable(opt_q))
        else $error("option byte changed in application mode");
    bulk_iap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (start_cmd && dat_i[3:0] == 4'h4 && !full_ok) |=> st_q == ST_IDLE)
        else $error("bulk erase started in application mode");
    sect_absent_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (start_cmd && dat_i[3:0] == 4'h2 && tsect > TOP_SECT) |=> st_q == ST_IDLE)
        else $error("erase of a missing sector started");
    read_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (protect && ext_read) |=> rdata_q == 8'h00)
        else $error("protected array read from outside");
    hold_protect_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q == ST_ERASE && then_unprot_q && cnt_q != '0) |=> protect)
        else $error("protection dropped before erase end");
    key_disarm_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_req && adr_i != GUARD_OFF) |=> !armed)
        else $error("guard still armed after another write");
endmodule

// ===== flash_ctrl_pkg.sv
/*
 flash program memory controller constants: register offsets, field positions,
 reset values, sector geometry and guard key values.
 assumes a byte-addressed flash array of at most 64 Kbytes.
*/
package flash_ctrl_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses on the bus)
    // ------------------------------------------------------------
    localparam logic [7:0] FPCS_OFF      = 8'h24;
    localparam logic [7:0] GUARD_OFF     = 8'h28;
    localparam logic [7:0] ADDR_OFF      = 8'h2c;
    localparam logic [7:0] DATA_OFF      = 8'h30;
    localparam logic [7:0] OPTION_OFF    = 8'h34;
    localparam logic [7:0] STATUS_OFF    = 8'h38;
    localparam logic [7:0] RDATA_OFF     = 8'h3c;
    localparam logic [7:0] FPCS_RESET    = 8'h00;
    localparam logic [7:0] OPTION_RESET  = 8'h00;
    // control fields of flash_program_control_status
    localparam int CTL_PROG_BIT          = 0;
    localparam int CTL_SECT_ERASE_BIT    = 1;
    localparam int CTL_BULK_ERASE_BIT    = 2;
    localparam int CTL_OPT_WRITE_BIT     = 3;
    localparam int CTL_SECT_LSB          = 4;
    // option byte field
    localparam int OPT_PROTECT_BIT       = 0;
    // status fields
    localparam int ST_BUSY_BIT           = 0;
    localparam int ST_REFUSED_BIT        = 1;
    localparam int ST_PROTECT_BIT        = 2;
    localparam int ST_TOOL_BIT           = 3;
    localparam int ST_ICC_BIT            = 4;
    localparam int ST_IAP_BIT            = 5;
    // two-key guard sequence
    localparam logic [7:0] GUARD_KEY1    = 8'h56;
    localparam logic [7:0] GUARD_KEY2    = 8'hae;
    // ------------------------------------------------------------
    // sector geometry
    // ------------------------------------------------------------
    localparam logic [15:0] SECT0_BASE   = 16'hf000;
    localparam logic [15:0] SECT1_BASE   = 16'he000;
    localparam int SECT_FIXED_BYTES      = 4096;
    localparam int SIZE_4K               = 4096;
    localparam int SIZE_8K               = 8192;
    localparam int LINK_SYNC_STAGES      = 2;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ERASE = 2'b01,
        ST_PROG  = 2'b10
    } op_state_t;
endpackage

// ===== link_tool_model.sv
/*
 programming tool model: serial clock, serial data and session select.
 assumes the bench says when the tool is plugged in and when a session runs.
*/
module link_tool_model (
    // control from the bench
    input  wire logic attach_i,
    input  wire logic session_i,
    // link pins
    output logic      link_clk_o,
    output logic      link_data_o,
    output logic      prog_sel_o,
    output logic      attached_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // pins and clock
    // ------------------------------------------------------------
    assign attached_o = attach_i;
    assign prog_sel_o = session_i;
    // clock runs only in a session; data keeps moving so no stale level is read
    initial begin
        link_clk_o  = 1'b0;
        link_data_o = 1'b0;
        #37;
        forever begin
            #80;
            link_clk_o = session_i ? ~link_clk_o : 1'b0;
            link_data_o = ~link_data_o;
        end
    end
endmodule

// ===== tb_flash_sector_program_protect.sv
/*
 bench for the flash controller: wishbone register tasks and a tool model.
 assumes an 8K array, so sector 2 is absent and an erase takes 8192 cycles.
*/
module tb_flash_sector_program_protect;
    import flash_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_i, rst_i, cyc, stb, we, ack_o;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, dat_o;
    logic        sd_o, sd_oe, avail, comm_mode, prot;
    logic        lclk, tdat, psel, att, attach, session, app_o, app_oe;
    wire logic   sdata = sd_oe ? sd_o : tdat;
    int          fail_count, total_checks;

    flash_sector_program_protect #(.FLASH_BYTES(8192)) flash_sector_program_protect_i (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(4'hf), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
        .incircuit_serial_clock(lclk), .incircuit_serial_data_i(sdata),
        .incircuit_serial_data_o(sd_o), .incircuit_serial_data_oe_o(sd_oe),
        .programming_voltage_select_i(psel), .tool_attached_i(att),
        .app_data_o_i(app_o), .app_data_oe_i(app_oe), .app_pins_avail_o(avail),
        .incircuit_comm_mode_o(comm_mode), .readout_protect_o(prot));
    link_tool_model link_tool_model_i (
        .attach_i(attach), .session_i(session), .link_clk_o(lclk),
        .link_data_o(tdat), .prog_sel_o(psel), .attached_o(att));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic results;
        if (fail_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: bit %b, expected %b", $time, got, exp);
        end
    endtask
    // one classic cycle; read data taken at the ack edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {16'h0000, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            $display("Error at %0t: no bus answer", $time);
            results();
        end
    endtask
    // guard keys, command, then poll busy with a bound above one erase
    task automatic cmd(input logic [7:0] c);
        int n;
        xfer(1'b1, GUARD_OFF, {8'h00, GUARD_KEY1});
        xfer(1'b1, GUARD_OFF, {8'h00, GUARD_KEY2});
        xfer(1'b1, FPCS_OFF, {8'h00, c});
        n = 0;
        do begin
            xfer(1'b0, STATUS_OFF, 16'h0000);
            n++;
        end while (rdat[ST_BUSY_BIT] !== 1'b0 && n < 4000);
        if (n >= 4000) begin
            fail_count++;
            $display("Error at %0t: operation never finished", $time);
            results();
        end
    endtask
    task automatic prog(input logic [15:0] a, input logic [7:0] d);
        xfer(1'b1, ADDR_OFF, a);
        xfer(1'b1, DATA_OFF, {8'h00, d});
        cmd(8'h01);
    endtask
    // read-back data lags the address by a cycle, so the second read counts
    task automatic chk_mem(input logic [15:0] a, input logic [7:0] exp);
        xfer(1'b1, ADDR_OFF, a);
        xfer(1'b0, RDATA_OFF, 16'h0000);
        xfer(1'b0, RDATA_OFF, 16'h0000);
        chk_byte(rdat[7:0], exp);
    endtask
    task automatic chk_refused(input logic exp);
        xfer(1'b0, STATUS_OFF, 16'h0000);
        chk_bit(rdat[ST_REFUSED_BIT], exp);
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        {cyc, stb, we, adr, wdat} = '0;
        {attach, session} = 2'b00;
        {app_o, app_oe} = 2'b11;
        fail_count = 0;
        total_checks = 0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        xfer(1'b0, FPCS_OFF, 16'h0000);
        chk_byte(rdat[7:0], FPCS_RESET);
        xfer(1'b0, 8'h00, 16'h0000);
        chk_byte(rdat[7:0], 8'h00);
        chk_bit(avail, 1'b1);
        chk_bit(sd_oe, 1'b1);
        chk_bit(sd_o, 1'b1);
        xfer(1'b0, STATUS_OFF, 16'h0000);
        chk_bit(rdat[ST_IAP_BIT], 1'b1);
        cmd(8'h12);
        chk_mem(16'he005, 8'hff);
        prog(16'he005, 8'h5a);
        chk_mem(16'he005, 8'h5a);
        chk_mem(16'he006, 8'hff);
        xfer(1'b1, ADDR_OFF, 16'he006);
        xfer(1'b1, FPCS_OFF, 16'h0001);
        chk_refused(1'b0);
        chk_mem(16'he006, 8'hff);
        cmd(8'h22);
        chk_refused(1'b1);
        cmd(8'h02);
        chk_refused(1'b1);
        prog(16'hf000, 8'h00);
        chk_refused(1'b1);
        cmd(8'h04);
        chk_refused(1'b1);
        chk_mem(16'he005, 8'h5a);
        // tool plugged in; no external reset during the session
        attach <= 1'b1;
        session <= 1'b1;
        repeat (200) @(posedge clk_i);  // margin for synchronisers on the slow link clock
        chk_bit(avail, 1'b0);
        chk_bit(sd_oe, 1'b0);
        chk_bit(comm_mode, 1'b1);
        chk_bit(sd_o, 1'b0);
        xfer(1'b0, STATUS_OFF, 16'h0000);
        chk_bit(rdat[ST_IAP_BIT], 1'b0);
        cmd(8'h02);
        chk_mem(16'hf000, 8'hff);
        prog(16'hf000, 8'h12);
        chk_mem(16'hf000, 8'h12);
        chk_mem(16'he005, 8'h5a);
        xfer(1'b1, DATA_OFF, 16'h0001);
        cmd(8'h08);
        chk_bit(prot, 1'b1);
        chk_mem(16'he005, 8'h00);
        prog(16'he006, 8'h00);
        chk_refused(1'b1);
        xfer(1'b1, DATA_OFF, 16'h0000);
        cmd(8'h08);
        chk_bit(prot, 1'b0);
        chk_mem(16'he005, 8'hff);
        chk_mem(16'hf000, 8'hff);
        results();
    end
endmodule
